// ### src/gct_pkg.sv
package gct_pkg;

    // ************************************************************
    // Serial frame layout
    // ************************************************************
    localparam int unsigned HDR_BITS  = 16;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned ADDR_BITS = 15;
    localparam int unsigned RW_POS    = 15;

    localparam logic [4:0] HDR_LAST  = 5'h0f;
    localparam logic [4:0] DATA_LAST = 5'h07;
    localparam logic [4:0] RD_COUNT  = 5'h08;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [14:0] DIVIDER_INIT_COMMAND_ADDR   = 15'h0071;
    localparam logic [14:0] LOOP_LOOP_LOCK_RETRY_REQUEST_COMMAND_ADDR    = 15'h0072;
    localparam logic [14:0] BIAS_CAL_AND_READ_EDGE_ADDR = 15'h0073;

    localparam int unsigned CMD_BIT_POS  = 7;
    localparam int unsigned EDGE_BIT_POS = 0;

    localparam logic       READ_EDGE_RESET = 1'h0;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        PH_HDR   = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ  = 2'b10,
        PH_DONE  = 2'b11
    } gct_phase_t;

    typedef struct packed {
        logic divider_init;
        logic loop_lock_retry_request;
        logic bias_calibration_start;
    } gct_cmd_t;

    typedef struct packed {
        logic oe;
        logic dout;
    } gct_line_t;

endpackage

// ### src/gct_cmd_bit.sv
`timescale 1ns/10ps
module gct_cmd_bit
(
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic done_i,
    output logic      pulse_o,
    output logic      busy_o
);
    import gct_pkg::*;

    logic pulse_reg;
    logic pulse_next;
    logic busy_reg;
    logic busy_next;

    // A new start while busy is dropped so the running job is not restarted
    always_comb
    begin
        pulse_next = set_i & ~busy_reg;
        busy_next  = busy_reg;
        if (done_i)
        begin
            busy_next = 1'b0;
        end
        // An accepted start wins over a done in the same cycle; a refused one
        // lets the done clear busy, so busy can never hang without a job running
        if (pulse_next)
        begin
            busy_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pulse_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end
        else
        begin
            pulse_reg <= pulse_next;
            busy_reg  <= busy_next;
        end
    end

    assign pulse_o = pulse_reg;
    assign busy_o  = busy_reg;
endmodule // gct_cmd_bit

// ### src/gct_top.sv
`timescale 1ns/10ps
module gct_top
(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic          serial_clk_i,
    input  wire logic          chip_sel_n_i,
    input  wire logic          serial_bidir_line_i,
    output logic               serial_bidir_line_o,
    output logic               serial_bidir_line_oe_o,
    input  wire logic          bias_cal_done_i,
    output gct_pkg::gct_cmd_t  cmd_o,
    output logic               bias_cal_busy_o,
    output logic               read_data_edge_select_o
);
    import gct_pkg::*;

    // ************************************************************
    // Serial clock edge detection
    // ************************************************************
    logic sclk_reg;
    logic sclk_next;
    logic rise;
    logic fall;
    logic launch;

    assign sclk_next = serial_clk_i;
    assign rise      = serial_clk_i & ~sclk_reg;
    assign fall      = ~serial_clk_i & sclk_reg;

    // ************************************************************
    // Frame state
    // ************************************************************
    gct_phase_t  phase_reg;
    gct_phase_t  phase_next;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic [15:0] hdr_reg;
    logic [15:0] hdr_next;
    logic [7:0]  wdat_reg;
    logic [7:0]  wdat_next;
    logic [7:0]  rdat_reg;
    logic [7:0]  rdat_next;
    gct_line_t   line_reg;
    gct_line_t   line_next;
    logic        edge_sel_reg;
    logic        edge_sel_next;

    logic        wr_init;
    logic        wr_loop_lock_retry_request;
    logic        wr_bias;
    logic        bias_busy;
    logic [15:0] hdr_full;
    logic [7:0]  wdat_full;
    logic [7:0]  read_value;

    // Host samples on the opposite edge from the one we launch on
    assign launch    = edge_sel_reg ? rise : fall;
    assign hdr_full  = {hdr_reg[14:0], serial_bidir_line_i};
    assign wdat_full = {wdat_reg[6:0], serial_bidir_line_i};

    // ************************************************************
    // Read decode
    // ************************************************************
    always_comb
    begin
        read_value = READ_ZERO;
        if (hdr_full[ADDR_BITS-1:0] == BIAS_CAL_AND_READ_EDGE_ADDR)
        begin
            read_value[CMD_BIT_POS]  = bias_busy;
            read_value[EDGE_BIT_POS] = edge_sel_reg;
        end
    end

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    always_comb
    begin
        phase_next    = phase_reg;
        cnt_next      = cnt_reg;
        hdr_next      = hdr_reg;
        wdat_next     = wdat_reg;
        rdat_next     = rdat_reg;
        line_next     = line_reg;
        edge_sel_next = edge_sel_reg;
        wr_init       = 1'b0;
        wr_loop_lock_retry_request     = 1'b0;
        wr_bias       = 1'b0;
        if (chip_sel_n_i)
        begin
            // Deselect aborts any frame; a partial write has no effect
            phase_next   = PH_HDR;
            cnt_next     = 5'h00;
            line_next.oe = 1'b0;
        end
        else
        begin
            unique case (phase_reg)
                PH_HDR:
                begin
                    if (rise)
                    begin
                        hdr_next = hdr_full;
                        cnt_next = cnt_reg + 5'h01;
                        if (cnt_reg == HDR_LAST)
                        begin
                            cnt_next = 5'h00;
                            if (hdr_full[RW_POS])
                            begin
                                phase_next = PH_READ;
                                rdat_next  = read_value;
                                // Rising launch: first bit goes out on this same edge
                                if (edge_sel_reg)
                                begin
                                    line_next.oe   = 1'b1;
                                    line_next.dout = read_value[7];
                                    rdat_next      = {read_value[6:0], 1'b0};
                                    cnt_next       = 5'h01;
                                end
                            end
                            else
                            begin
                                phase_next = PH_WRITE;
                            end
                        end
                    end
                end
                PH_WRITE:
                begin
                    if (rise)
                    begin
                        wdat_next = wdat_full;
                        cnt_next  = cnt_reg + 5'h01;
                        if (cnt_reg == DATA_LAST)
                        begin
                            phase_next = PH_DONE;
                            unique case (hdr_reg[ADDR_BITS-1:0])
                                DIVIDER_INIT_COMMAND_ADDR:
                                begin
                                    wr_init = wdat_full[CMD_BIT_POS];
                                end
                                LOOP_LOOP_LOCK_RETRY_REQUEST_COMMAND_ADDR:
                                begin
                                    wr_loop_lock_retry_request = wdat_full[CMD_BIT_POS];
                                end
                                BIAS_CAL_AND_READ_EDGE_ADDR:
                                begin
                                    wr_bias       = wdat_full[CMD_BIT_POS];
                                    edge_sel_next = wdat_full[EDGE_BIT_POS];
                                end
                                default:
                                begin
                                    // Unmapped addresses are ignored
                                end
                            endcase
                        end
                    end
                end
                PH_READ:
                begin
                    if (launch)
                    begin
                        if (cnt_reg == RD_COUNT)
                        begin
                            line_next.oe = 1'b0;
                            phase_next   = PH_DONE;
                        end
                        else
                        begin
                            line_next.oe   = 1'b1;
                            line_next.dout = rdat_reg[7];
                            rdat_next      = {rdat_reg[6:0], 1'b0};
                            cnt_next       = cnt_reg + 5'h01;
                        end
                    end
                end
                PH_DONE:
                begin
                    // Extra clocks until deselect are ignored
                    line_next.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            sclk_reg     <= 1'b0;
            phase_reg    <= PH_HDR;
            cnt_reg      <= 5'h00;
            hdr_reg      <= 16'h0000;
            wdat_reg     <= 8'h00;
            rdat_reg     <= 8'h00;
            line_reg     <= '0;
            edge_sel_reg <= READ_EDGE_RESET;
        end
        else
        begin
            sclk_reg     <= sclk_next;
            phase_reg    <= phase_next;
            cnt_reg      <= cnt_next;
            hdr_reg      <= hdr_next;
            wdat_reg     <= wdat_next;
            rdat_reg     <= rdat_next;
            line_reg     <= line_next;
            edge_sel_reg <= edge_sel_next;
        end
    end

    // ************************************************************
    // Self-clearing commands
    // ************************************************************
    gct_cmd_bit u_init
    (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .set_i     (wr_init),
        .done_i    (1'b1),
        .pulse_o   (cmd_o.divider_init),
        .busy_o    ()
    );

    gct_cmd_bit u_loop_lock_retry_request
    (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .set_i     (wr_loop_lock_retry_request),
        .done_i    (1'b1),
        .pulse_o   (cmd_o.loop_lock_retry_request),
        .busy_o    ()
    );

    // Busy holds until the analog side reports the end of calibration
    gct_cmd_bit u_bias
    (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .set_i     (wr_bias),
        .done_i    (bias_cal_done_i),
        .pulse_o   (cmd_o.bias_calibration_start),
        .busy_o    (bias_busy)
    );

    assign bias_cal_busy_o         = bias_busy;
    assign serial_bidir_line_o     = line_reg.dout;
    assign serial_bidir_line_oe_o  = line_reg.oe;
    assign read_data_edge_select_o = edge_sel_reg;
endmodule // gct_top

// ### tb/gct_host_model.sv
`timescale 1ns/10ps
module gct_host_model
(
    input  wire logic  sys_clk_i,
    input  wire logic  dev_line_i,
    input  wire logic  dev_oe_i,
    output logic       serial_clk_o,
    output logic       chip_sel_n_o,
    output logic       line_o,
    output logic       rd_done_o,
    output logic [7:0] rd_data_o
);
    logic host_oe = 1'b0;
    logic host_d  = 1'b1;

    // Pull-up: a released line reads high, never the last driven bit
    assign line_o = dev_oe_i ? dev_line_i : (host_oe ? host_d : 1'b1);

    initial
    begin
        serial_clk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        rd_done_o = 1'b0;
        rd_data_o = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Clock rests low outside frames; 4 system clocks per phase
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                        input logic edge_sel, input int nbits);
        logic [23:0] frame;
        frame = {rd, addr, wd};
        tick(1);
        chip_sel_n_o = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            host_oe = !(rd && i >= 16);
            host_d = frame[23 - i];
            tick(4);
            if (rd && !edge_sel && i >= 16) rd_data_o = {rd_data_o[6:0], line_o};
            serial_clk_o = 1'b1;
            tick(4);
            if (rd && edge_sel && i >= 15 && i <= 22) rd_data_o = {rd_data_o[6:0], line_o};
            serial_clk_o = 1'b0;
        end
        tick(4);
        chip_sel_n_o = 1'b1;
        host_oe = 1'b0;
        rd_done_o = rd && nbits == 24;
        tick(1);
        rd_done_o = 1'b0;
        tick(1);
    endtask
endmodule // gct_host_model

// ### tb/gct_checker.sv
`timescale 1ns/10ps
module gct_checker
(
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic              serial_clk_i,
    input wire logic              chip_sel_n_i,
    input wire logic              serial_bidir_line_i,
    input wire logic              serial_bidir_line_o,
    input wire logic              serial_bidir_line_oe_o,
    input wire logic              bias_cal_done_i,
    input wire gct_pkg::gct_cmd_t cmd_o,
    input wire logic              bias_cal_busy_o,
    input wire logic              read_data_edge_select_o
);
    import gct_pkg::*;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_div;
        cmd_o.divider_init |=> !cmd_o.divider_init;
    endproperty
    a_div: assert property (p_div) else $error("divider pulse too long");
    property p_loop_lock_retry_request;
        cmd_o.loop_lock_retry_request |=> !cmd_o.loop_lock_retry_request;
    endproperty
    a_loop_lock_retry_request: assert property (p_loop_lock_retry_request) else $error("loop_lock_retry_request pulse too long");
    property p_start;
        cmd_o.bias_calibration_start |-> $rose(bias_cal_busy_o);
    endproperty
    a_start: assert property (p_start) else $error("start without fresh busy");
    property p_busy_src;
        $rose(bias_cal_busy_o) |-> cmd_o.bias_calibration_start;
    endproperty
    a_busy_src: assert property (p_busy_src) else $error("busy without start");
    property p_busy_end;
        bias_cal_busy_o && bias_cal_done_i |=> !bias_cal_busy_o || cmd_o.bias_calibration_start;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy kept after done");
    property p_reset;
        disable iff (1'b0) rst_i |=> cmd_o == 3'h0 && !bias_cal_busy_o
            && !read_data_edge_select_o && !serial_bidir_line_oe_o;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_launch;
        $changed(serial_bidir_line_o) && serial_bidir_line_oe_o
            |-> $past(serial_clk_i) == read_data_edge_select_o;
    endproperty
    a_launch: assert property (p_launch) else $error("read bit on wrong edge");
    property p_release;
        $rose(chip_sel_n_i) |-> ##[1:4] !serial_bidir_line_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("line held after deselect");
    c_div: cover property (cmd_o.divider_init);
    c_done: cover property (bias_cal_busy_o && bias_cal_done_i);
    c_rise_read: cover property (serial_bidir_line_oe_o && read_data_edge_select_o);
endmodule // gct_checker

bind gct_top gct_checker u_checker (.sys_clk_i, .rst_i, .serial_clk_i, .chip_sel_n_i,
    .serial_bidir_line_i, .serial_bidir_line_o, .serial_bidir_line_oe_o, .bias_cal_done_i,
    .cmd_o, .bias_cal_busy_o, .read_data_edge_select_o);

// ### tb/gct_top_test.sv
`timescale 1ns/10ps
module gct_top_test;
    import gct_pkg::*;
    logic        sys_clk_i, rst_i, sclk, cs_n, line, dev_d, dev_oe, done, busy, edge_sel;
    logic        rd_done, edge_cur;
    logic [7:0]  rd_data;
    logic [8:0]  exp_q[$];
    logic [31:0] seed;
    logic [31:0] r;
    logic [14:0] a;
    gct_cmd_t    cmd;
    int          err_count = 0;
    int          checks_done = 0;
    int          cycles = 0;

    gct_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .serial_clk_i(sclk), .chip_sel_n_i(cs_n),
        .serial_bidir_line_i(line), .serial_bidir_line_o(dev_d), .serial_bidir_line_oe_o(dev_oe),
        .bias_cal_done_i(done), .cmd_o(cmd), .bias_cal_busy_o(busy),
        .read_data_edge_select_o(edge_sel));
    gct_host_model host (.sys_clk_i(sys_clk_i), .dev_line_i(dev_d), .dev_oe_i(dev_oe),
        .serial_clk_o(sclk), .chip_sel_n_o(cs_n), .line_o(line), .rd_done_o(rd_done),
        .rd_data_o(rd_data));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [14:0] ad, input logic [7:0] d, input logic [2:0] pulse);
        if (pulse != 3'h0) exp_q.push_back({6'h00, pulse});
        host.xfer(1'b0, ad, d, edge_cur, 24);
        if (ad == BIAS_CAL_AND_READ_EDGE_ADDR) edge_cur = d[EDGE_BIT_POS];
    endtask

    task automatic rd(input logic [14:0] ad, input logic [7:0] d);
        exp_q.push_back({1'b1, d});
        host.xfer(1'b1, ad, 8'h00, edge_cur, 24);
    endtask

    task automatic finish_cal;
        done = 1'b1;
        host.tick(1);
        done = 1'b0;
    endtask

    // Each command pulse or finished read takes the oldest note
    // Sampled mid-cycle so the launching edge never races the compare
    always @(negedge sys_clk_i)
        if (!rst_i && (cmd !== 3'h0 || rd_done === 1'b1))
            check("result", rd_done ? {1'b1, rd_data} : {6'h00, cmd},
                  exp_q.size() ? exp_q.pop_front() : 9'bx);

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    initial
    begin
        rst_i = 1'b1;
        done = 1'b0;
        edge_cur = 1'b0;
        seed = 32'hd5aa;
        host.tick(2);
        rst_i = 1'b0;
        rd(15'h0073, 8'h00);
        rd(15'h0071, 8'h00);
        rd(15'h0072, 8'h00);
        $display("test reset_readback done");
        wr(15'h0071, 8'h80, 3'h4);
        wr(15'h0071, 8'h00, 3'h0);
        wr(15'h0072, 8'h80, 3'h2);
        wr(15'h0073, 8'h80, 3'h1);
        check("busy", {8'h00, busy}, 9'h001);
        rd(15'h0073, 8'h80);
        wr(15'h0073, 8'h80, 3'h0);
        finish_cal();
        check("idle", {8'h00, busy}, 9'h000);
        rd(15'h0073, 8'h00);
        $display("test commands done");
        wr(15'h0073, 8'h01, 3'h0);
        check("edge", {8'h00, edge_sel}, 9'h001);
        rd(15'h0073, 8'h01);
        wr(15'h0073, 8'h81, 3'h1);
        rd(15'h0073, 8'h81);
        finish_cal();
        wr(15'h0073, 8'h00, 3'h0);
        rd(15'h7f00, 8'h00);
        host.xfer(1'b0, 15'h0071, 8'h80, edge_cur, 20);
        // Mid-run reset with the rising-edge mode selected must fall back to falling
        wr(15'h0073, 8'h01, 3'h0);
        rst_i = 1'b1;
        host.tick(2);
        rst_i = 1'b0;
        edge_cur = READ_EDGE_RESET;
        check("edge_rst", {8'h00, edge_sel}, 9'h000);
        rd(15'h0073, 8'h00);
        $display("test edge_and_abort done");
        for (int k = 0; k < 8; k++)
        begin
            r = $random(seed);
            a = r[0] ? 15'h0071 + 15'(r[1]) : {r[16:3], 1'b0};
            wr(a, {r[20], 7'h00}, {a == 15'h0071 && r[20], a == 15'h0072 && r[20], 1'b0});
        end
        host.tick(20);
        check("pending", 9'(exp_q.size()), 9'h000);
        $display("test random done");
        print_verdict();
    end
endmodule // gct_top_test
